// [fast_pulse_counter_pkg.sv]
// Shared constants for the four-channel fast pulse counter front end.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
package fast_pulse_counter_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned NS_PER_US        = 1000;
  localparam int unsigned TICK_US          = 1;
  localparam int unsigned TICK_CYCLES      = TICK_US * NS_PER_US
                                             / CLK_PERIOD_NS;
  localparam int unsigned DIV_W            = 7;
  localparam logic [DIV_W-1:0] DIV_LAST    = DIV_W'(TICK_CYCLES - 1);
  localparam int unsigned RESET_LATENCY_US = 100;
  localparam int unsigned US_PER_SEC       = 1000000;

  // Frequency sample windows, in timebase ticks of one microsecond
  localparam int unsigned WIN0_US_DEF = 1000;
  localparam int unsigned WIN1_US_DEF = 10000;
  localparam int unsigned WIN2_US_DEF = 100000;
  localparam int unsigned WIN3_US_DEF = 1000000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned NCH           = 4;
  localparam logic [7:0] OFS_POLARITY   = 8'h00;
  localparam logic [7:0] OFS_PROG_RESET = 8'h04;
  localparam logic [7:0] OFS_LEVELS     = 8'h08;
  localparam logic [7:0] OFS_CFG_BASE   = 8'h10;
  localparam logic [7:0] OFS_WRAP_BASE  = 8'h20;
  localparam logic [7:0] OFS_MEAS_BASE  = 8'h30;
  localparam logic [2:0] SIZE_WORD      = 3'h2;

  // Channel configuration fields
  localparam int unsigned CFG_MODE_LSB  = 0;
  localparam int unsigned CFG_MODE_MSB  = 1;
  localparam int unsigned CFG_EDGE_BIT  = 2;
  localparam int unsigned CFG_WIN_LSB   = 3;
  localparam int unsigned CFG_WIN_MSB   = 4;
  localparam int unsigned CFG_HWEN_BIT  = 5;
  localparam int unsigned CFG_HWFALL_BIT = 6;
  localparam int unsigned CFG_W         = 7;

  // Reset values
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
  localparam logic [31:0] WRAP_RESET     = 32'h0;
  localparam logic [NCH-1:0] PROG_RESET  = 4'h0;

  typedef enum logic [1:0] {
    MODE_FREQUENCY  = 2'b00,
    MODE_TOTALIZE   = 2'b01,
    MODE_PULSE      = 2'b10,
    MODE_QUADRATURE = 2'b11
  } mode_type;

  // Chooses the rising or falling edge strobe
  function automatic logic pick_edge(input logic rise,
                                     input logic fall,
                                     input logic use_fall);
    return use_fall ? fall : rise;
  endfunction

endpackage

// [pulse_channel.sv]
// One counter channel: frequency window and totalizer with wrap limit.
// Assumes edge strobes valid only while step is high, once per tick.
`timescale 1ns/1ns
module pulse_channel
  import fast_pulse_counter_pkg::*;
#(
  parameter int unsigned WIN0_US = WIN0_US_DEF,
  parameter int unsigned WIN1_US = WIN1_US_DEF,
  parameter int unsigned WIN2_US = WIN2_US_DEF,
  parameter int unsigned WIN3_US = WIN3_US_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        step,
  input  wire logic        rise,
  input  wire logic        fall,
  input  wire logic        neg,
  input  wire mode_type    mode,
  input  wire logic        edge_fall,
  input  wire logic [1:0]  win_sel,
  input  wire logic [31:0] wrap,
  input  wire logic        prog_rst,
  input  wire logic        hw_rst,
  output logic      [31:0] meas
);

  logic [31:0] tot_q;
  logic [31:0] freq_q;
  logic [31:0] edges_q;
  logic [31:0] win_q;
  logic [31:0] meas_q;
  logic [31:0] win_last;
  logic [31:0] win_scale;
  logic [31:0] edges_sum;
  logic [63:0] prod;
  logic        count_edge;
  logic        freq_edge;
  logic        wrap_hit;

  // ----------------------------------------------------------------
  // Edge selection and window constants
  // ----------------------------------------------------------------
  assign count_edge = pick_edge(rise, fall, edge_fall);
  assign freq_edge  = pick_edge(rise, fall, neg);
  assign wrap_hit   = (wrap != 32'h0) && (tot_q == wrap - 32'h1);
  assign edges_sum  = edges_q + {31'h0, freq_edge};
  assign prod       = edges_sum * win_scale;

  // Window length and count-to-hertz scale per selection
  always_comb begin
    case (win_sel)
      2'h0: begin
        win_last  = WIN0_US - 1;
        win_scale = US_PER_SEC / WIN0_US;
      end
      2'h1: begin
        win_last  = WIN1_US - 1;
        win_scale = US_PER_SEC / WIN1_US;
      end
      2'h2: begin
        win_last  = WIN2_US - 1;
        win_scale = US_PER_SEC / WIN2_US;
      end
      default: begin
        win_last  = WIN3_US - 1;
        win_scale = US_PER_SEC / WIN3_US;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Totalizer
  // ----------------------------------------------------------------
  // Any reset beats a counted edge in the same tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tot_q <= 32'h0;
    end else if (prog_rst || hw_rst) begin
      tot_q <= 32'h0;
    end else if (step && mode == MODE_TOTALIZE && count_edge) begin
      if (wrap_hit) begin
        tot_q <= 32'h0;
      end else begin
        tot_q <= tot_q + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frequency window
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win_q   <= 32'h0;
      edges_q <= 32'h0;
      freq_q  <= 32'h0;
    end else if (mode != MODE_FREQUENCY) begin
      win_q   <= 32'h0;
      edges_q <= 32'h0;
      freq_q  <= 32'h0;
    end else if (step) begin
      if (win_q >= win_last) begin
        freq_q  <= prod[31:0];
        edges_q <= 32'h0;
        win_q   <= 32'h0;
      end else begin
        edges_q <= edges_sum;
        win_q   <= win_q + 32'h1;
      end
    end
  end

  // Result word by mode; pulse and quadrature modes read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meas_q <= 32'h0;
    end else begin
      case (mode)
        MODE_TOTALIZE:  meas_q <= tot_q;
        MODE_FREQUENCY: meas_q <= freq_q;
        default:        meas_q <= 32'h0;
      endcase
    end
  end

  assign meas = meas_q;

  AST_WRAP_TO_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    (step && mode == MODE_TOTALIZE && count_edge && !prog_rst && !hw_rst
     && wrap != 32'h0 && tot_q == wrap - 32'h1) |=> tot_q == 32'h0)
    else $error("totalizer did not wrap at limit");

  AST_FULL_RANGE: assert property (@(posedge hclk) disable iff (!hresetn)
    (step && mode == MODE_TOTALIZE && count_edge && !prog_rst && !hw_rst
     && wrap == 32'h0 && tot_q != 32'hffffffff)
    |=> tot_q == $past(tot_q) + 32'h1)
    else $error("totalizer did not count through full range");

endmodule

// [fast_pulse_counter.sv]
// Four-channel fast pulse counter front end with an AHB-Lite slave.
// Assumes field inputs synchronous to hclk and one bus master.
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module fast_pulse_counter
  import fast_pulse_counter_pkg::*;
#(
  parameter int unsigned WIN0_US = WIN0_US_DEF,
  parameter int unsigned WIN1_US = WIN1_US_DEF,
  parameter int unsigned WIN2_US = WIN2_US_DEF,
  parameter int unsigned WIN3_US = WIN3_US_DEF,
  parameter int unsigned RESET_LATENCY_CYCLES =
    RESET_LATENCY_US * NS_PER_US / CLK_PERIOD_NS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        counter_input_one,
  input  wire logic        counter_input_two,
  input  wire logic        reset_source_input_three,
  input  wire logic        reset_source_input_four
);

  // Cycles from the eighth quiet cycle to the next tick
  localparam int TICK_REST = TICK_CYCLES - 8;
  localparam int HW_CLEAR_MAX = 3;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_q;
  logic             tick_q;
  logic             step_q;
  logic [NCH-1:0]   pins;
  logic [NCH-1:0]   pin_q;
  logic [NCH-1:0]   prev_q;
  logic [NCH-1:0]   rise;
  logic [NCH-1:0]   fall;
  logic [NCH-1:0]   sensed;
  logic             neg_q;
  logic [NCH-1:0]   prog_q;
  logic [CFG_W-1:0] cfg_q [NCH];
  logic [31:0]      wrap_q [NCH];
  logic [31:0]      meas [NCH];
  mode_type         mode [NCH];
  logic [1:0]       hw_req;
  logic [NCH-1:0]   hw_vec;
  logic             accept;
  logic             wr_q;
  logic [7:0]       wa_q;
  logic [31:0]      rd_d;
  logic [31:0]      hrdata_q;
  logic             hreadyout_q;
  logic             hresp_q;

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  // True when the address hits one word register
  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [7:0]  ofs);
    return addr == {24'h0, ofs};
  endfunction

  // True when the address falls in a four-word channel bank
  function automatic logic bank_hit(input logic [31:0] addr,
                                    input logic [7:0]  base);
    return (addr[31:4] == {24'h0, base[7:4]}) && (addr[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  // One-cycle enable every microsecond
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_LAST) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  AST_TICK_PERIOD: assert property (@(posedge hclk) disable iff (!hresetn)
    tick_q |=> !tick_q [*8] ##TICK_REST tick_q)
    else $error("timebase tick not every microsecond");

  // ----------------------------------------------------------------
  // Input sampling and edge detection
  // ----------------------------------------------------------------
  assign pins = {reset_source_input_four, reset_source_input_three,
                 counter_input_two, counter_input_one};

  // Raw levels taken once per tick; edges valid in the step cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q  <= '0;
      prev_q <= '0;
      step_q <= 1'b0;
    end else begin
      step_q <= tick_q;
      if (tick_q) begin
        prev_q <= pin_q;
        pin_q  <= pins;
      end
    end
  end

  assign rise   = pin_q & ~prev_q;
  assign fall   = ~pin_q & prev_q;
  assign sensed = pin_q ^ {NCH{neg_q}};

  // ----------------------------------------------------------------
  // Hardware reset from channels three and four
  // ----------------------------------------------------------------
  // Only a totalizing target may be reset, and only on a chosen edge
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      hw_req[k] = step_q
        && cfg_q[k+2][CFG_HWEN_BIT]
        && mode[k] == MODE_TOTALIZE
        && pick_edge(rise[k+2], fall[k+2],
                     cfg_q[k+2][CFG_HWFALL_BIT]);
    end
  end

  assign hw_vec = {2'b00, hw_req};

  AST_HW_ONLY_TOTALIZE: assert property (@(posedge hclk)
    disable iff (!hresetn)
    hw_req[0] |-> (mode[0] == MODE_TOTALIZE
                   && cfg_q[2][CFG_HWEN_BIT]
                   && $past(tick_q)
                   && pin_q[2] != prev_q[2]))
    else $error("hardware reset on a non-totalizing channel");

  AST_HW_EDGE_POL: assert property (@(posedge hclk) disable iff (!hresetn)
    hw_req[1] |-> (pin_q[3] == !cfg_q[3][CFG_HWFALL_BIT]))
    else $error("hardware reset on the wrong edge");

  AST_HW_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn)
    (hw_req[0] && $stable(mode[0]))
    |-> ##[1:HW_CLEAR_MAX] meas[0] == 32'h0)
    else $error("hardware reset did not clear channel one");

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign mode[i] = mode_type'(cfg_q[i][CFG_MODE_MSB:CFG_MODE_LSB]);

    pulse_channel #(
      .WIN0_US (WIN0_US),
      .WIN1_US (WIN1_US),
      .WIN2_US (WIN2_US),
      .WIN3_US (WIN3_US)
    ) u_ch (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .step      (step_q),
      .rise      (rise[i]),
      .fall      (fall[i]),
      .neg       (neg_q),
      .mode      (mode[i]),
      .edge_fall (cfg_q[i][CFG_EDGE_BIT]),
      .win_sel   (cfg_q[i][CFG_WIN_MSB:CFG_WIN_LSB]),
      .wrap      (wrap_q[i]),
      .prog_rst  (prog_q[i]),
      .hw_rst    (hw_vec[i]),
      .meas      (meas[i])
    );
  end

  // ----------------------------------------------------------------
  // Bus slave: address phase
  // ----------------------------------------------------------------
  assign accept = hsel && htrans[1] && hready;

  // Remember a word write for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h0;
    end else if (hready) begin
      wr_q <= accept && hwrite && hsize == SIZE_WORD
              && haddr[31:8] == 24'h0 && haddr[1:0] == 2'h0;
      wa_q <= haddr[7:0];
    end
  end

  // Read data chosen at the address phase; unmapped reads zero
  always_comb begin
    rd_d = 32'h0;
    if (reg_hit(haddr, OFS_POLARITY)) begin
      rd_d[0] = neg_q;
    end else if (reg_hit(haddr, OFS_PROG_RESET)) begin
      rd_d[NCH-1:0] = prog_q;
    end else if (reg_hit(haddr, OFS_LEVELS)) begin
      rd_d[NCH-1:0] = sensed;
    end else if (bank_hit(haddr, OFS_CFG_BASE)) begin
      rd_d[CFG_W-1:0] = cfg_q[haddr[3:2]];
    end else if (bank_hit(haddr, OFS_WRAP_BASE)) begin
      rd_d = wrap_q[haddr[3:2]];
    end else if (bank_hit(haddr, OFS_MEAS_BASE)) begin
      rd_d = meas[haddr[3:2]];
    end
  end

  // Response registers; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q    <= 32'h0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (accept && !hwrite) begin
        hrdata_q <= rd_d;
      end
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;

  // ----------------------------------------------------------------
  // Bus slave: data phase writes
  // ----------------------------------------------------------------
  // Shared polarity and program reset bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      neg_q  <= 1'b0;
      prog_q <= PROG_RESET;
    end else if (wr_q) begin
      if (wa_q == OFS_POLARITY) begin
        neg_q <= hwdata[0];
      end
      if (wa_q == OFS_PROG_RESET) begin
        prog_q <= hwdata[NCH-1:0];
      end
    end
  end

  // Per-channel configuration and wrap limits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < NCH; k++) begin
        cfg_q[k]  <= CFG_RESET;
        wrap_q[k] <= WRAP_RESET;
      end
    end else if (wr_q) begin
      if (wa_q[7:4] == OFS_CFG_BASE[7:4]) begin
        cfg_q[wa_q[3:2]] <= hwdata[CFG_W-1:0];
      end
      if (wa_q[7:4] == OFS_WRAP_BASE[7:4]) begin
        wrap_q[wa_q[3:2]] <= hwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks on the bus and channel outputs
  // ----------------------------------------------------------------
  AST_BUS_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
    accept |=> (hreadyout && !hresp))
    else $error("slave not ready or not OKAY");

  AST_MEAS_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite && haddr == {24'h0, OFS_MEAS_BASE})
    |=> hrdata == $past(meas[0]))
    else $error("measurement read returned wrong word");

  AST_LEVEL_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite && haddr == {24'h0, OFS_LEVELS})
    |=> hrdata[0] == ($past(pin_q[0]) ^ $past(neg_q)))
    else $error("sensed level not inverted by polarity");

  AST_PROG_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && hwrite && hsize == SIZE_WORD
     && haddr == {24'h0, OFS_PROG_RESET})
    |=> ##1 prog_q == $past(hwdata[NCH-1:0]))
    else $error("program reset bits not written");

  AST_PROG_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (prog_q[0] && mode[0] == MODE_TOTALIZE)
    |-> ##2 (meas[0] == 32'h0 || $past(mode[0]) != MODE_TOTALIZE))
    else $error("program reset did not hold total at zero");

  // ----------------------------------------------------------------
  // Reset latency watch for channel one
  // ----------------------------------------------------------------
  logic        src_prev_q;
  logic        lat_pend_q;
  logic [31:0] lat_cnt_q;
  logic        lat_start;

  assign lat_start = cfg_q[2][CFG_HWEN_BIT]
    && mode[0] == MODE_TOTALIZE
    && pick_edge(reset_source_input_three && !src_prev_q,
                 !reset_source_input_three && src_prev_q,
                 cfg_q[2][CFG_HWFALL_BIT]);

  // Counts cycles from a qualifying pin edge until the total reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev_q <= 1'b0;
      lat_pend_q <= 1'b0;
      lat_cnt_q  <= 32'h0;
    end else begin
      src_prev_q <= reset_source_input_three;
      if (lat_start) begin
        lat_pend_q <= 1'b1;
        lat_cnt_q  <= 32'h0;
      end else if (meas[0] == 32'h0 || mode[0] != MODE_TOTALIZE) begin
        lat_pend_q <= 1'b0;
      end else if (lat_pend_q) begin
        lat_cnt_q <= lat_cnt_q + 32'h1;
      end
    end
  end

  AST_HW_LATENCY: assert property (@(posedge hclk) disable iff (!hresetn)
    lat_pend_q |-> lat_cnt_q < RESET_LATENCY_CYCLES)
    else $error("hardware reset latency exceeded");

endmodule

// [pulse_source.sv]
// Field pulse source model driving the four counter pins.
// Assumes the bench sets want; each pin follows once its gap ran out.
`timescale 1ns/1ns
module pulse_source #(
  parameter int GAP = 10000
) (
  input  wire logic       hclk,
  input  wire logic [3:0] want,
  output logic      [3:0] pin
);
  int gap_q [4] = '{GAP, GAP, GAP, GAP};

  initial pin = 4'h0;

  // Each pin moves toward want only after its minimum edge spacing
  always @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (gap_q[i] < GAP) begin
        gap_q[i] <= gap_q[i] + 1;
      end else if (want[i] !== pin[i]) begin
        pin[i]   <= want[i];
        gap_q[i] <= 0;
      end
    end
  end
endmodule

// [fast_pulse_counter_tb.sv]
// Self-checking bench for the fast pulse counter front end.
// Assumes one AHB-Lite master here and the pulse source on the pins.
`timescale 1ns/1ns
module fast_pulse_counter_tb import fast_pulse_counter_pkg::*; ();
  localparam int          GAP  = 300; // Three ticks keeps sampling exact
  localparam logic [31:0] POL  = 32'(OFS_POLARITY);
  localparam logic [31:0] PRST = 32'(OFS_PROG_RESET);
  localparam logic [31:0] LVL  = 32'(OFS_LEVELS);
  localparam logic [31:0] CFG  = 32'(OFS_CFG_BASE);
  localparam logic [31:0] WRP  = 32'(OFS_WRAP_BASE);
  localparam logic [31:0] MEA  = 32'(OFS_MEAS_BASE);
  localparam int          WIN [4] = '{10, 20, 40, 50};

  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic        hready, hreadyout, hresp, run;
  logic [3:0]  want = 4'h0, pin;
  int          mismatches = 0, num_checks = 0, n, w;
  int          exp_tot [4] = '{0, 0, 0, 0};

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  fast_pulse_counter #(.WIN0_US(WIN[0]), .WIN1_US(WIN[1]),
    .WIN2_US(WIN[2]), .WIN3_US(WIN[3])) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(SIZE_WORD),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .counter_input_one(pin[0]), .counter_input_two(pin[1]),
    .reset_source_input_three(pin[2]), .reset_source_input_four(pin[3]));

  pulse_source #(.GAP(GAP)) src_u (.hclk(hclk), .want(want), .pin(pin));

  // ------------------------------------------------------------
  // Bus, pin and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %h out of %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Waits for hready high at a rising edge, bounded
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: bus hang", $time);
    end
  endtask

  task automatic bus(input logic w_en, input logic [31:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w_en;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic meas(input int c, input logic [31:0] e);
    bus(1'b0, MEA + 32'(4 * c), 32'h0);
    chk(32'(hresp), 32'h0);
    chk(rd, e);
  endtask

  task automatic pins_to(input logic [3:0] v);
    int k;
    k = 0;
    want <= v;
    do begin
      @(posedge hclk);
      k++;
    end while (pin !== v && k < 4 * GAP);
    if (pin !== v) begin
      mismatches++;
      $display("unexpected at %0t: pins stuck", $time);
    end
  endtask

  // One tick plus the update latency
  task automatic settle;
    repeat (110) @(posedge hclk);
  endtask

  task automatic pulse(input logic [3:0] m, input int cnt);
    repeat (cnt) begin
      pins_to(want | m);
      pins_to(want & ~m);
    end
    settle();
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h50f6));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, 32'h40, 32'hffffffff);
    bus(1'b1, 32'h0c, 32'hffffffff);
    for (int a = 0; a <= 32'h40; a += 4) begin
      bus(1'b0, 32'(a), 32'h0);
      chk(rd, 32'h0);
    end
    $display("reset values finished");
    bus(1'b1, CFG, 32'h01);
    bus(1'b1, CFG + 32'h4, 32'h05);
    n = $urandom_range(5, 2);
    pulse(4'h3, n);
    exp_tot[0] += n;
    exp_tot[1] += n;
    meas(0, exp_tot[0]);
    meas(1, exp_tot[1]);
    bus(1'b1, POL, 32'h1);
    bus(1'b0, LVL, 32'h0);
    chk(rd, 32'hf);
    pulse(4'h1, n);
    exp_tot[0] += n;
    meas(0, exp_tot[0]);
    bus(1'b1, POL, 32'h0);
    $display("totalize finished");
    w = $urandom_range(4, 2);
    bus(1'b1, WRP, 32'(w));
    bus(1'b1, PRST, 32'h1);
    exp_tot[0] = 0;
    pulse(4'h1, 1);
    meas(0, 32'h0);
    bus(1'b1, PRST, 32'h0);
    pulse(4'h1, w + 1);
    repeat (w + 1) exp_tot[0] = (exp_tot[0] + 1) % w;
    meas(0, exp_tot[0]);
    $display("wrap and program reset finished");
    bus(1'b1, CFG + 32'h8, 32'h20);
    pins_to(4'h4);
    settle();
    meas(0, 32'h0);
    pulse(4'h1, 1);
    meas(0, 32'h1);
    pins_to(4'h0);
    settle();
    meas(0, 32'h1);
    bus(1'b1, CFG + 32'h8, 32'h60);
    pins_to(4'h4);
    settle();
    meas(0, 32'h1);
    pins_to(4'h0);
    settle();
    meas(0, 32'h0);
    bus(1'b1, CFG + 32'h4, 32'h06);
    settle();
    meas(1, 32'h0);
    bus(1'b1, CFG + 32'h4, 32'h05);
    bus(1'b1, CFG + 32'hc, 32'h20);
    meas(1, exp_tot[1]);
    pins_to(4'h8);
    settle();
    exp_tot[1] = 0;
    meas(1, exp_tot[1]);
    $display("hardware reset finished");
    run = 1'b1;
    fork
      while (run) pins_to(want ^ 4'h2);
    join_none
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, CFG + 32'h4, 32'(s << CFG_WIN_LSB));
      repeat (300 * WIN[s]) @(posedge hclk);
      bus(1'b0, MEA + 32'h4, 32'h0);
      chk_rng(rd, (WIN[s] / 6 - 1) * 1000000 / WIN[s],
              (WIN[s] / 6 + 1) * 1000000 / WIN[s]);
    end
    run = 1'b0;
    $display("frequency finished");
    print_verdict();
  end

  // Watchdog beyond the expected run of about 45000 cycles
  initial begin
    repeat (90000) @(posedge hclk);
    mismatches++;
    print_verdict();
  end
endmodule
